// ===== tccu_top.sv
// timer capture/compare channel with an axi4-lite register slave
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module tccu_top
  import tccu_pkg::*;
#(
  parameter int unsigned CW = CNT_W
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              capture_input_a,
  input  wire logic              capture_input_b,
  input  wire logic              gate_timer_flipflop,
  output logic                   pulse_output,
  output logic                   match_b_irq,
  output logic                   ext_irq_a,
  output logic                   ext_irq_b
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] merge(input logic [CW-1:0] old,
                                          input logic [31:0]   wd,
                                          input logic [3:0]    st);
    logic [CW-1:0] r;
    r = old;
    for (int i = 0; i < CW / 8; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic tap_tick(input logic [PRE_W-1:0] p,
                                    input logic [1:0]       s);
    logic [PRE_W-1:0] m;
    m = PRE_W'((32'd1 << (TAP_STEP * s)) - 32'd1);
    return (p & m) == m;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic              run_q;
  logic              prun_q;
  tccu_mode_t        mode_q;
  tccu_ffcr_t        ffcr_q;
  logic [CW-1:0]     cmpa_q;
  logic [CW-1:0]     cmpb_q;
  logic [CW-1:0]     capa_q;
  logic [CW-1:0]     capb_q;
  logic [CW-1:0]     cnt_q;
  logic [PRE_W-1:0]  pre_q;
  logic [ST_W-1:0]   stat_q;
  logic              ff_q;
  logic              a_meta_q;
  logic              a_sync_q;
  logic              a_prev_q;
  logic              b_meta_q;
  logic              b_sync_q;
  logic              b_prev_q;
  logic              g_prev_q;
  tccu_pair_t        pair_q;
  logic [31:0]       rd_d;
  logic              rd_ok;

  wire logic aw_take  = awvalid & awready;
  wire logic w_take   = wvalid & wready;
  wire logic ar_take  = arvalid & arready;
  wire logic do_write = aw_have_q & w_have_q & ~bvalid;
  wire logic [ADDR_W-1:0] wa = {aw_addr_q[ADDR_W-1:2], 2'b00};
  wire logic [ADDR_W-1:0] ra = {araddr[ADDR_W-1:2], 2'b00};
  wire logic wr_ctrl = do_write & (wa == OFS_CTRL);
  wire logic wr_ffcr = do_write & (wa == OFS_FFCR);
  wire logic wr_stat = do_write & (wa == OFS_STAT);
  wire logic wr_ok   = (wa == OFS_CTRL) | (wa == OFS_MODE) | (wa == OFS_FFCR)
                     | (wa == OFS_CMPA) | (wa == OFS_CMPB) | (wa == OFS_CAPA)
                     | (wa == OFS_CAPB) | (wa == OFS_CNT)  | (wa == OFS_STAT);

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are taken independently; the response waits for both
  always_ff @(posedge clock) begin
    if (!nrst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      if (aw_take) begin
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      aw_have_q <= do_write ? 1'b0 : (aw_have_q | aw_take);
      w_have_q  <= do_write ? 1'b0 : (w_have_q | w_take);
      awready   <= do_write | ~(aw_have_q | aw_take);
      wready    <= do_write | ~(w_have_q | w_take);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_d  = '0;
    rd_ok = 1'b1;
    unique case (ra)
      OFS_CTRL: begin
        rd_d[CTRL_RUN]  = run_q;
        rd_d[CTRL_PRUN] = prun_q;
      end
      OFS_MODE: rd_d[$bits(tccu_mode_t)-1:0] = mode_q;
      OFS_FFCR: begin
        rd_d[$bits(tccu_ffcr_t)-1:0] = ffcr_q;
        rd_d[FF_STATE]               = ff_q;
      end
      OFS_CMPA: rd_d[CW-1:0] = cmpa_q;
      OFS_CMPB: rd_d[CW-1:0] = cmpb_q;
      OFS_CAPA: rd_d[CW-1:0] = capa_q;
      OFS_CAPB: rd_d[CW-1:0] = capb_q;
      OFS_CNT:  rd_d[CW-1:0] = cnt_q;
      OFS_STAT: rd_d[ST_W-1:0] = stat_q;
      default:  rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (ar_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_d;
      rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid) begin
      rvalid  <= ~rready;
      arready <= rready;
    end else begin
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // the gate flip-flop comes from logic on this clock, so it is not synchronised
  always_ff @(posedge clock) begin
    if (!nrst) begin
      a_meta_q <= 1'b0;
      a_sync_q <= 1'b0;
      a_prev_q <= 1'b0;
      b_meta_q <= 1'b0;
      b_sync_q <= 1'b0;
      b_prev_q <= 1'b0;
      g_prev_q <= 1'b0;
    end else begin
      a_meta_q <= capture_input_a;
      a_sync_q <= a_meta_q;
      a_prev_q <= a_sync_q;
      b_meta_q <= capture_input_b;
      b_sync_q <= b_meta_q;
      b_prev_q <= b_sync_q;
      g_prev_q <= gate_timer_flipflop;
    end
  end

  wire logic a_rise = a_sync_q & ~a_prev_q;
  wire logic a_fall = ~a_sync_q & a_prev_q;
  wire logic b_rise = b_sync_q & ~b_prev_q;
  wire logic g_rise = gate_timer_flipflop & ~g_prev_q;
  wire logic g_fall = ~gate_timer_flipflop & g_prev_q;

  // ----------------------------------------------------------------
  // prescaler and up-counter
  // ----------------------------------------------------------------
  // the external clock is gated by the prescaler run bit too
  wire logic ext_clk = (mode_q.clk_sel == CLK_EXT);
  wire logic tick = run_q & prun_q
                  & (ext_clk ? a_rise : tap_tick(pre_q, mode_q.clk_sel));
  wire logic [CW-1:0] cnt_nx = cnt_q + CW'(1);
  wire logic match_a = tick & (cnt_nx == cmpa_q);
  wire logic match_b = tick & (cnt_nx == cmpb_q);

  always_ff @(posedge clock) begin
    if (!nrst || !prun_q) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  // stopping the run bit clears the counter
  always_ff @(posedge clock) begin
    if (!nrst || !run_q) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_nx;
    end
  end

  // ----------------------------------------------------------------
  // capture triggers
  // ----------------------------------------------------------------
  wire logic pair_src = (mode_q.cap_sel == CAP_GATE);
  wire logic p_rise = pair_src ? g_rise : a_rise;
  wire logic p_fall = pair_src ? g_fall : a_fall;
  wire logic paired = (mode_q.cap_sel == CAP_EDGE_PAIR) | pair_src;
  wire logic cap_a_ev = (mode_q.cap_sel != CAP_OFF) & p_rise;
  wire logic cap_b_ev = paired ? (p_fall & (pair_q == PAIR_WAIT_FALL))
                               : ((mode_q.cap_sel == CAP_TWO_PIN) & b_rise);

  // the pair state re-arms after every falling capture, so pairs repeat
  always_ff @(posedge clock) begin
    if (!nrst || !paired) begin
      pair_q <= PAIR_WAIT_RISE;
    end else if (p_rise) begin
      pair_q <= PAIR_WAIT_FALL;
    end else if (cap_b_ev) begin
      pair_q <= PAIR_WAIT_RISE;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      capa_q <= '0;
      capb_q <= '0;
    end else begin
      if (cap_a_ev) begin
        capa_q <= cnt_q;
      end
      if (cap_b_ev) begin
        capb_q <= cnt_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      run_q  <= 1'b0;
      prun_q <= 1'b0;
      mode_q <= RST_MODE;
      ffcr_q <= RST_FFCR;
      cmpa_q <= '0;
      cmpb_q <= '0;
    end else if (do_write) begin
      if (wr_ctrl && w_strb_q[0]) begin
        run_q  <= w_data_q[CTRL_RUN];
        prun_q <= w_data_q[CTRL_PRUN];
      end
      if (wa == OFS_MODE && w_strb_q[0]) begin
        mode_q <= w_data_q[$bits(tccu_mode_t)-1:0];
      end
      if (wr_ffcr && w_strb_q[0]) begin
        ffcr_q <= w_data_q[$bits(tccu_ffcr_t)-1:0];
      end
      if (wa == OFS_CMPA) begin
        cmpa_q <= merge(cmpa_q, w_data_q, w_strb_q);
      end
      if (wa == OFS_CMPB) begin
        cmpb_q <= merge(cmpb_q, w_data_q, w_strb_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // timer flip-flop
  // ----------------------------------------------------------------
  // matches in one cycle cancel, since two toggles leave the level unchanged
  wire logic tog = (ffcr_q.tog_a & match_a)
                 ^ (ffcr_q.tog_b & match_b)
                 ^ (ffcr_q.tog_cap_a & cap_a_ev);
  wire logic sw_set = wr_ffcr & w_strb_q[0] & w_data_q[FF_SET];
  wire logic sw_clr = wr_ffcr & w_strb_q[0] & w_data_q[FF_CLR];

  // a software set or clear gives the initial level and wins over a toggle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ff_q <= 1'b0;
    end else if (sw_clr) begin
      ff_q <= 1'b0;
    end else if (sw_set) begin
      ff_q <= 1'b1;
    end else if (tog) begin
      ff_q <= ~ff_q;
    end
  end

  assign pulse_output = ff_q;

  // ----------------------------------------------------------------
  // event flags and interrupt lines
  // ----------------------------------------------------------------
  wire logic [ST_W-1:0] st_set = {cap_b_ev, cap_a_ev, match_b, match_a};
  wire logic [ST_W-1:0] st_clr = (wr_stat & w_strb_q[0]) ? w_data_q[ST_W-1:0] : '0;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      stat_q      <= '0;
      match_b_irq <= 1'b0;
      ext_irq_a   <= 1'b0;
      ext_irq_b   <= 1'b0;
    end else begin
      stat_q      <= (stat_q & ~st_clr) | st_set; // set wins over clear
      match_b_irq <= match_b;
      ext_irq_a   <= a_sync_q;
      ext_irq_b   <= b_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  cnt_step_a: assert property (@(posedge clock) disable iff (!nrst)
    tick |=> cnt_q == $past(cnt_q) + CW'(1)) else $error("counter missed a tick");
  cnt_wrap_a: assert property (@(posedge clock) disable iff (!nrst)
    tick && (&cnt_q) |=> cnt_q == '0) else $error("counter did not wrap to zero");
  ext_clk_a: assert property (@(posedge clock) disable iff (!nrst)
    run_q && prun_q && ext_clk && a_rise && !wr_ctrl |=> cnt_q != $past(cnt_q))
    else $error("external edge did not step counter");
  cap_a_load_a: assert property (@(posedge clock) disable iff (!nrst)
    cap_a_ev |=> capa_q == $past(cnt_q)) else $error("capture a value wrong");
  cap_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !cap_a_ev && !cap_b_ev |=> $stable(capa_q) && $stable(capb_q))
    else $error("capture register changed without trigger");
  pair_arm_a: assert property (@(posedge clock) disable iff (!nrst)
    mode_q.cap_sel == CAP_EDGE_PAIR && a_rise |=> pair_q == PAIR_WAIT_FALL)
    else $error("edge pair not armed by rise");
  pair_fall_a: assert property (@(posedge clock) disable iff (!nrst)
    mode_q.cap_sel == CAP_EDGE_PAIR && pair_q == PAIR_WAIT_FALL && a_fall
    |=> capb_q == $past(cnt_q)) else $error("edge pair fall capture missed");
  two_pin_a: assert property (@(posedge clock) disable iff (!nrst)
    mode_q.cap_sel == CAP_TWO_PIN && b_rise |=> capb_q == $past(cnt_q))
    else $error("input b capture missed");
  gate_rise_a: assert property (@(posedge clock) disable iff (!nrst)
    mode_q.cap_sel == CAP_GATE && g_rise |=> capa_q == $past(cnt_q))
    else $error("gate rise capture missed");
  ff_toggle_a: assert property (@(posedge clock) disable iff (!nrst)
    ffcr_q.tog_a && ffcr_q.tog_b && !ffcr_q.tog_cap_a && (match_a != match_b)
    && !sw_set && !sw_clr |=> pulse_output != $past(pulse_output))
    else $error("flip-flop did not toggle on match");
  irq_b_a: assert property (@(posedge clock) disable iff (!nrst)
    match_b |=> match_b_irq && stat_q[ST_MATCH_B]) else $error("match b irq missing");

endmodule

// ===== tccu_pkg.sv
// constants and carrier types for the timer capture/compare unit
package tccu_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned PRE_W    = 6;
  localparam int unsigned TAP_STEP = 2;
  localparam int unsigned ADDR_W   = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FFCR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CMPA = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CMPB = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAPA = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CAPB = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CNT  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_RUN  = 0;
  localparam int unsigned CTRL_PRUN = 1;
  localparam int unsigned FF_SET    = 4;
  localparam int unsigned FF_CLR    = 5;
  localparam int unsigned FF_STATE  = 6;
  localparam int unsigned ST_MATCH_A = 0;
  localparam int unsigned ST_MATCH_B = 1;
  localparam int unsigned ST_CAP_A   = 2;
  localparam int unsigned ST_CAP_B   = 3;
  localparam int unsigned ST_W       = 4;

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CLK_EXT       = 2'h0;
  localparam logic [1:0] CAP_OFF       = 2'h0;
  localparam logic [1:0] CAP_TWO_PIN   = 2'h1;
  localparam logic [1:0] CAP_EDGE_PAIR = 2'h2;
  localparam logic [1:0] CAP_GATE      = 2'h3;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic [1:0] cap_sel;
    logic [1:0] clk_sel;
  } tccu_mode_t;

  typedef struct packed {
    logic tog_cap_a;
    logic tog_b;
    logic tog_a;
  } tccu_ffcr_t;

  localparam tccu_mode_t RST_MODE = 4'h0;
  localparam tccu_ffcr_t RST_FFCR = 3'h0;

  typedef enum logic {PAIR_WAIT_RISE, PAIR_WAIT_FALL} tccu_pair_t;

endpackage

// ===== tccu_pin_model.sv
// pin-side model: capture input pins and the gate timer flip-flop level
`timescale 1ns/1ps
module tccu_pin_model (
  input  wire logic clock,
  output logic      capture_input_a,
  output logic      capture_input_b,
  output logic      gate_timer_flipflop
);
  initial begin
    capture_input_a     = 1'b0;
    capture_input_b     = 1'b0;
    gate_timer_flipflop = 1'b0;
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // levels move just after an edge, so no capture races the sampler
  task automatic drive(input int which, input logic val);
    @(posedge clock);
    case (which)
      0: capture_input_a <= val;
      1: capture_input_b <= val;
      default: gate_timer_flipflop <= val;
    endcase
  endtask

  // high for high_cyc clock cycles, then low
  task automatic pulse(input int which, input int high_cyc);
    drive(which, 1'b1);
    repeat (high_cyc - 1) @(posedge clock);
    drive(which, 1'b0);
  endtask
endmodule

// ===== test_tccu_top.sv
// self-checking bench for the timer capture/compare unit
`timescale 1ns/1ps
module test_tccu_top;
  import tccu_pkg::*;
  logic              clock;
  logic              nrst;
  logic [ADDR_W-1:0] awaddr;
  logic [ADDR_W-1:0] araddr;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [31:0]       wdata, rdata, v, c, c2, c3;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              cap_a, cap_b, gate_ff;
  logic              pulse_output, match_b_irq, ext_irq_a, ext_irq_b;
  logic              last_out = 1'b0;
  int                errors = 0;
  int                n_compared = 0;
  int                hi_cnt = 0;
  int                rises = 0;
  int                h0, r0;

  tccu_top dut (.clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .capture_input_a(cap_a), .capture_input_b(cap_b), .gate_timer_flipflop(gate_ff),
    .pulse_output(pulse_output), .match_b_irq(match_b_irq), .ext_irq_a(ext_irq_a),
    .ext_irq_b(ext_irq_b));

  tccu_pin_model pins (.clock(clock), .capture_input_a(cap_a), .capture_input_b(cap_b),
    .gate_timer_flipflop(gate_ff));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // pulse output monitor: high cycles and rising edges
  always @(posedge clock) begin
    last_out <= pulse_output;
    if (pulse_output === 1'b1) hi_cnt <= hi_cnt + 1;
    if (pulse_output === 1'b1 && last_out === 1'b0) rises <= rises + 1;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic hang(input string what);
    errors++;
    $display("[FAIL] %0t timeout on %s", $time, what);
    final_report();
  endtask

  function automatic logic [15:0] dif(input logic [31:0] a, input logic [31:0] b);
    return a[15:0] - b[15:0];
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite master
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    int   n;
    logic aw_p, w_p, b_p;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    for (n = 0; n < 200 && b_p; n++) begin
      @(posedge clock);
      if (aw_p && awready === 1'b1) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (w_p && wready === 1'b1) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (!aw_p && !w_p && bvalid === 1'b1) begin
        b_p = 1'b0;
        bready <= 1'b0;
        check(bresp === exp, "write response");
      end
    end
    if (b_p) hang("write");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] exp);
    int   n;
    logic ar_p, r_p;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_p = 1'b1;
    r_p = 1'b1;
    for (n = 0; n < 200 && r_p; n++) begin
      @(posedge clock);
      if (ar_p && arready === 1'b1) begin
        ar_p = 1'b0;
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (!ar_p && rvalid === 1'b1) begin
        r_p = 1'b0;
        rready <= 1'b0;
        d = rdata;
        check(rresp === exp, "read response");
      end
    end
    if (r_p) hang("read");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic tick;
    pins.pulse(0, 4);
    cyc(4);
  endtask

  task automatic wait_match_b;
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge clock);
      if (match_b_irq === 1'b1) break;
    end
    if (n >= 3000) hang("match b interrupt");
  endtask

  // software sees input a fall on its external interrupt line
  task automatic wait_fall_a;
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (ext_irq_a === 1'b0) break;
    end
    if (n >= 50) hang("input a fall");
  endtask

  task automatic done(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    awaddr = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = '0;
    wstrb = 4'hF;
    cyc(12);
    nrst <= 1'b1;
    rd(OFS_CNT, v, RESP_OKAY);
    check(v === 32'h0, "counter not clear after reset");
    rd(OFS_MODE, v, RESP_OKAY);
    check(v === 32'h0, "mode not clear after reset");
    wr(8'h24, 32'h1, RESP_SLVERR);
    rd(8'h24, v, RESP_SLVERR);
    done("reset");
    // external clock counts only with the prescaler running
    wr(OFS_MODE, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    repeat (5) tick();
    rd(OFS_CNT, v, RESP_OKAY);
    check(v === 32'h0, "counted with prescaler stopped");
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    repeat (5) tick();
    rd(OFS_CNT, v, RESP_OKAY);
    check(v === 32'd5, "external edge count");
    wr(OFS_CNT, 32'h1234, RESP_OKAY);
    rd(OFS_CNT, v, RESP_OKAY);
    check(v === 32'd5, "counter written");
    done("event count");
    // gate flip-flop frames ten external edges
    wr(OFS_MODE, 32'hC, RESP_OKAY);
    pins.drive(2, 1'b1);
    cyc(10);
    repeat (10) tick();
    cyc(10);
    pins.drive(2, 1'b0);
    cyc(10);
    rd(OFS_CAPA, c, RESP_OKAY);
    rd(OFS_CAPB, c2, RESP_OKAY);
    check(c === 32'd5 && c2 === 32'd15, "gate capture pair");
    done("gate");
    // two-input time difference on the div4 tap
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_CNT, v, RESP_OKAY);
    check(v === 32'h0, "stop does not clear");
    wr(OFS_MODE, 32'h5, RESP_OKAY);
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    pins.pulse(0, 10);
    cyc(89);
    fork
      pins.pulse(1, 12);
      begin
        cyc(6);
        check(ext_irq_b === 1'b1 && ext_irq_a === 1'b0, "external lines");
      end
    join
    cyc(6);
    rd(OFS_CAPA, c, RESP_OKAY);
    rd(OFS_CAPB, c2, RESP_OKAY);
    check(dif(c2, c) >= 16'd24 && dif(c2, c) <= 16'd26, "rise to rise");
    cyc(300);
    rd(OFS_CAPA, v, RESP_OKAY);
    check(v === c, "capture a not held");
    rd(OFS_CNT, v, RESP_OKAY);
    check(dif(v, c2) > 16'd70, "counter not running");
    done("two input");
    // edge pair on input a, measured twice
    wr(OFS_MODE, 32'h9, RESP_OKAY);
    pins.pulse(0, 60);
    wait_fall_a();
    cyc(4);
    rd(OFS_CAPA, c, RESP_OKAY);
    rd(OFS_CAPB, c2, RESP_OKAY);
    check(dif(c2, c) >= 16'd14 && dif(c2, c) <= 16'd16, "high width");
    cyc(40);
    pins.pulse(0, 20);
    wait_fall_a();
    cyc(4);
    rd(OFS_CAPA, v, RESP_OKAY);
    rd(OFS_CAPB, c3, RESP_OKAY);
    check(dif(v, c2) >= 16'd10 && v !== c, "low phase");
    check(dif(c3, v) >= 16'd4 && dif(c3, v) <= 16'd6, "second width");
    done("edge pair");
    // delayed one-shot: delay 40 counts, width 20 counts
    wr(OFS_MODE, 32'h5, RESP_OKAY);
    wr(OFS_FFCR, 32'h20, RESP_OKAY);
    check(pulse_output === 1'b0, "flip-flop clear");
    pins.pulse(0, 10);
    cyc(6);
    rd(OFS_CAPA, c, RESP_OKAY);
    wr(OFS_CMPA, {16'h0, c[15:0] + 16'd40}, RESP_OKAY);
    wr(OFS_CMPB, {16'h0, c[15:0] + 16'd60}, RESP_OKAY);
    wr(OFS_STAT, 32'hF, RESP_OKAY);
    h0 = hi_cnt;
    r0 = rises;
    wr(OFS_FFCR, 32'h3, RESP_OKAY);
    wait_match_b();
    wr(OFS_FFCR, 32'h0, RESP_OKAY);
    rd(OFS_STAT, v, RESP_OKAY);
    check(v[ST_MATCH_B] === 1'b1, "match b status");
    cyc(40);
    check(pulse_output === 1'b0 && rises - r0 == 1, "one pulse");
    check(hi_cnt - h0 >= 76 && hi_cnt - h0 <= 84, "pulse width");
    done("one-shot");
    // zero-delay one-shot started by the capture itself, width 30 counts
    wr(OFS_FFCR, 32'h24, RESP_OKAY);
    check(pulse_output === 1'b0, "flip-flop clear");
    h0 = hi_cnt;
    r0 = rises;
    pins.pulse(0, 10);
    cyc(6);
    check(pulse_output === 1'b1, "capture toggle");
    rd(OFS_CAPA, c, RESP_OKAY);
    wr(OFS_CMPB, {16'h0, c[15:0] + 16'd30}, RESP_OKAY);
    wr(OFS_FFCR, 32'h2, RESP_OKAY);
    wait_match_b();
    wr(OFS_FFCR, 32'h0, RESP_OKAY);
    cyc(20);
    check(pulse_output === 1'b0 && rises - r0 == 1, "one pulse");
    check(hi_cnt - h0 >= 112 && hi_cnt - h0 <= 128, "pulse width");
    done("zero delay");
    // sticky status, write-1 clear, software set and clear of the flip-flop
    rd(OFS_STAT, v, RESP_OKAY);
    check(v[ST_MATCH_A] === 1'b1 && v[ST_CAP_A] === 1'b1, "match a status");
    wr(OFS_STAT, 32'hF, RESP_OKAY);
    rd(OFS_STAT, v, RESP_OKAY);
    check(v === 32'h0, "status not cleared");
    wr(OFS_FFCR, 32'h10, RESP_OKAY);
    check(pulse_output === 1'b1, "flip-flop set");
    wr(OFS_FFCR, 32'h30, RESP_OKAY);
    check(pulse_output === 1'b0, "clear wins over set");
    done("flags");
    // slow prescaler taps: div16 and div64 each give about ten counts
    for (int s = 2; s < 4; s++) begin
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
      wr(OFS_MODE, s, RESP_OKAY);
      wr(OFS_CTRL, 32'h3, RESP_OKAY);
      cyc(160 << (2 * s - 4));
      rd(OFS_CNT, v, RESP_OKAY);
      check(v >= 32'd9 && v <= 32'd11, "prescaler tap count");
    end
    done("taps");
    // reset in mid-run clears counter, capture a and the flip-flop
    wr(OFS_FFCR, 32'h10, RESP_OKAY);
    nrst <= 1'b0;
    cyc(3);
    nrst <= 1'b1;
    rd(OFS_CNT, v, RESP_OKAY);
    check(v === 32'h0 && pulse_output === 1'b0, "reset in mid-run");
    rd(OFS_CAPA, v, RESP_OKAY);
    check(v === 32'h0, "capture a after reset");
    done("mid-run reset");
    final_report();
  end
endmodule
